// ---- ccp_timer_partner.sv ----
// Behavioural model of the on-chip timers that feed the dual capture/compare block
`timescale 1ns/1ps
module ccp_timer_partner #(
  parameter logic [7:0] PWM_TOP = 8'h0f // Last count of the PWM timer period
) (
  input  wire logic        clk_i,        // Core clock
  input  wire logic        rst_i,        // Synchronous reset, active high
  input  wire logic        run_i,        // Sixteen bit timer counts while high
  input  wire logic        load_i,       // Load the sixteen bit timer
  input  wire logic [15:0] load_val_i,   // Value to load
  input  wire logic        tb16_reset_i, // Special event trigger from the block
  output logic      [15:0] tb16_o,       // Sixteen bit timer value
  output logic      [7:0]  pwm_tb_o,     // PWM timer value
  output logic             pwm_period_o  // Period pulse, timer at zero
);
  // Sixteen bit timer; a trigger wins over counting, as the real timer clears at once
  always_ff @(posedge clk_i)
  begin
    if (rst_i || tb16_reset_i) tb16_o <= 16'h0000;
    else if (load_i) tb16_o <= load_val_i;
    else if (run_i) tb16_o <= tb16_o + 16'h0001;
  end
  // PWM timer runs free; both units see one period, so they share frequency
  always_ff @(posedge clk_i)
  begin
    if (rst_i || pwm_tb_o == PWM_TOP) pwm_tb_o <= 8'h00;
    else pwm_tb_o <= pwm_tb_o + 8'h01;
  end
  assign pwm_period_o = (pwm_tb_o == 8'h00);
endmodule : ccp_timer_partner

// ---- ccp_unit.sv ----
// One capture/compare/PWM unit holding its sixteen bit value register
`timescale 1ns/1ps
`include "dual_ccp_consts.svh"
module ccp_unit (
  input  wire logic clk_i, // Core clock
  input  wire logic rst_i, // Synchronous reset, active high
  ccp_unit_if.unit  bus    // Control, data and events
);
  import dual_ccp_pkg::*;

  unit_kind_e kind;
  logic [3:0] mode;
  logic [3:0] mode_q;
  logic [3:0] presc_q;
  logic [3:0] presc_end;
  logic [1:0] duty_lo_q;
  logic [9:0] duty;
  logic [9:0] pwm_pos;
  word16_t    value_q;
  logic       pin_q;
  logic       rise;
  logic       fall;
  logic       multi;
  logic       cap_edge;
  logic       match_now;
  logic       match_q;
  logic       cmp_hit;
  logic       out_q;
  logic       event_q;
  logic       special_q;

  // Mode decode and edge detection on the already synchronised pin
  assign mode      = bus.ctrl[`CTRL_MODE_HI:`CTRL_MODE_LO];
  assign kind      = decode_kind(mode);
  assign rise      = bus.pin_sync & ~pin_q;
  assign fall      = ~bus.pin_sync & pin_q;
  assign multi     = (mode == `MODE_CAP_RISE4) || (mode == `MODE_CAP_RISE16);
  assign presc_end = (mode == `MODE_CAP_RISE16) ? `PRESC_SIXTEEN_END : `PRESC_FOUR_END;

  always_ff @(posedge clk_i)
  begin
    pin_q  <= rst_i ? 1'b0 : bus.pin_sync;
    mode_q <= rst_i ? `MODE_OFF : mode;
  end

  // Edge prescaler; any mode change clears it one cycle later, so a stale count can still fire on an edge in that first cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i || (mode != mode_q) || (kind != UNIT_CAPTURE))
      presc_q <= `PRESC_RESET;
    else if (rise && multi)
      presc_q <= (presc_q == presc_end) ? `PRESC_RESET : presc_q + 4'h1;
  end

  assign cap_edge = (kind == UNIT_CAPTURE) &&
                    (((mode == `MODE_CAP_FALL) && fall) || ((mode == `MODE_CAP_RISE) && rise) ||
                     (multi && rise && (presc_q == presc_end)));

  // Compare against the sixteen bit time base, one hit per arrival at the match
  assign match_now = (kind == UNIT_COMPARE) && (bus.tb16 == value_q);
  assign cmp_hit   = match_now && !match_q;

  always_ff @(posedge clk_i)
  begin
    match_q <= rst_i ? 1'b0 : match_now;
  end

  // Value register: capture overwrites even an unread value; PWM copies the duty into the high byte
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      value_q <= `VALUE_RESET;
    else if (cap_edge)
      value_q <= bus.tb16;
    else
    begin
      if (bus.wr_low)
        value_q[7:0] <= bus.wdata;
      if (kind == UNIT_PWM && bus.pwm_period)
        value_q[15:8] <= value_q[7:0];
      else if (bus.wr_high && kind != UNIT_PWM)
        value_q[15:8] <= bus.wdata;
    end
  end

  // Two low duty bits take effect only at a period boundary, like the upper eight
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      duty_lo_q <= `DUTY_LO_RESET;
    else if (kind == UNIT_PWM && bus.pwm_period)
      duty_lo_q <= bus.ctrl[`CTRL_DUTY_HI:`CTRL_DUTY_LO];
  end

  assign duty    = {value_q[15:8], duty_lo_q};
  assign pwm_pos = {bus.pwm_tb, 2'b00};

  // Output pin per mode
  always_ff @(posedge clk_i)
  begin
    if (rst_i || kind == UNIT_OFF)
      out_q <= 1'b0;
    else if (kind == UNIT_COMPARE && mode != mode_q)
      out_q <= (mode == `MODE_CMP_CLR);
    else if (cmp_hit && mode == `MODE_CMP_SET)
      out_q <= 1'b1;
    else if (cmp_hit && mode == `MODE_CMP_CLR)
      out_q <= 1'b0;
    else if (kind == UNIT_PWM && bus.pwm_period)
      out_q <= ({value_q[7:0], bus.ctrl[`CTRL_DUTY_HI:`CTRL_DUTY_LO]} != 10'h000);
    else if (kind == UNIT_PWM && pwm_pos >= duty)
      out_q <= 1'b0;
  end

  // Event and special trigger pulses
  always_ff @(posedge clk_i)
  begin
    event_q   <= rst_i ? 1'b0 : (cap_edge || cmp_hit);
    special_q <= rst_i ? 1'b0 : (cmp_hit && mode == `MODE_CMP_SPECIAL);
  end

  assign bus.value     = value_q;
  assign bus.event_p   = event_q;
  assign bus.special_p = special_q;
  assign bus.pin_o     = out_q;

  // Checks on the unit's own behaviour
  chk_capture_takes_base: assert property (@(posedge clk_i) disable iff (rst_i)
    cap_edge |=> (value_q == $past(bus.tb16)) && event_q)
    else $error("capture did not load the time base");
  chk_duty_slave_load: assert property (@(posedge clk_i) disable iff (rst_i)
    (kind == UNIT_PWM && bus.pwm_period) |=> (value_q[15:8] == $past(value_q[7:0]))
      && (duty_lo_q == $past(bus.ctrl[`CTRL_DUTY_HI:`CTRL_DUTY_LO]))) else $error("duty not latched at period");
  chk_off_pin_low: assert property (@(posedge clk_i) disable iff (rst_i)
    (kind == UNIT_OFF) |=> !out_q && (presc_q == `PRESC_RESET)) else $error("disabled unit not reset");
endmodule : ccp_unit

// ---- ccp_unit_if.sv ----
// Carrier between the register front end and one capture/compare/PWM unit
`timescale 1ns/1ps
interface ccp_unit_if;
  import dual_ccp_pkg::*;
  byte_t   ctrl;       // Control register contents
  logic    wr_low;     // Software writes the low byte
  logic    wr_high;    // Software writes the high byte
  byte_t   wdata;      // Byte written by software
  logic    pin_sync;   // Synchronised unit pin
  word16_t tb16;       // Sixteen bit time base value
  byte_t   pwm_tb;     // PWM time base value
  logic    pwm_period; // PWM period pulse
  word16_t value;      // Unit value register
  logic    event_p;    // Capture or compare event pulse
  logic    special_p;  // Special event trigger pulse
  logic    pin_o;      // Unit output pin level
  modport unit (input ctrl, wr_low, wr_high, wdata, pin_sync, tb16, pwm_tb, pwm_period,
                output value, event_p, special_p, pin_o);
  modport ctl  (output ctrl, wr_low, wr_high, wdata, pin_sync, tb16, pwm_tb, pwm_period,
                input value, event_p, special_p, pin_o);
endinterface : ccp_unit_if

// ---- dual_ccp_consts.svh ----
// Offsets, field positions, reset values and mode codes of the dual capture/compare block
`ifndef DUAL_CCP_CONSTS_SVH
`define DUAL_CCP_CONSTS_SVH
`define ADR_FIRST_CTRL   8'h00
`define ADR_FIRST_LOW    8'h04
`define ADR_FIRST_HIGH   8'h08
`define ADR_SECOND_CTRL  8'h0c
`define ADR_SECOND_LOW   8'h10
`define ADR_SECOND_HIGH  8'h14
`define ADR_EVENT_STATUS 8'h18
`define ADR_EVENT_MASK   8'h1c
`define CTRL_RESET       8'h00
`define CTRL_IMPL_MASK   8'h3f
`define CTRL_DUTY_HI     5
`define CTRL_DUTY_LO     4
`define CTRL_MODE_HI     3
`define CTRL_MODE_LO     0
`define MODE_OFF         4'h0
`define MODE_CAP_FALL    4'h4
`define MODE_CAP_RISE    4'h5
`define MODE_CAP_RISE4   4'h6
`define MODE_CAP_RISE16  4'h7
`define MODE_CMP_SET     4'h8
`define MODE_CMP_CLR     4'h9
`define MODE_CMP_FLAG    4'ha
`define MODE_CMP_SPECIAL 4'hb
`define KIND_CAPTURE     2'h1
`define KIND_COMPARE     2'h2
`define KIND_PWM         2'h3
`define PRESC_FOUR_END   4'h3
`define PRESC_SIXTEEN_END 4'hf
`define PRESC_RESET      4'h0
`define VALUE_RESET      16'h0000
`define DUTY_LO_RESET    2'h0
`define EVENT_RESET      2'h0
`define RDATA_RESET      32'h0000_0000
`define PAD_BITS         24'h00_0000
`endif

// ---- dual_ccp_pkg.sv ----
// Types and decode functions shared by the dual capture/compare block
package dual_ccp_pkg;
`include "dual_ccp_consts.svh"

  typedef logic [7:0]  byte_t;
  typedef logic [15:0] word16_t;

  // Operating kind decoded from the four mode bits
  typedef enum logic [2:0] {UNIT_OFF, UNIT_RESERVED, UNIT_CAPTURE, UNIT_COMPARE, UNIT_PWM} unit_kind_e;

  // Register selected by a bus address
  typedef enum logic [3:0] {REG_FIRST_CTRL, REG_FIRST_LOW, REG_FIRST_HIGH, REG_SECOND_CTRL, REG_SECOND_LOW,
                            REG_SECOND_HIGH, REG_STATUS, REG_MASK, REG_NONE} reg_sel_e;

  function automatic unit_kind_e decode_kind(input logic [3:0] mode);
    unit_kind_e k;
    k = UNIT_RESERVED;
    case (mode[3:2])
      `KIND_CAPTURE: k = UNIT_CAPTURE;
      `KIND_COMPARE: k = UNIT_COMPARE;
      `KIND_PWM:     k = UNIT_PWM;
      default:       k = (mode == `MODE_OFF) ? UNIT_OFF : UNIT_RESERVED;
    endcase
    return k;
  endfunction : decode_kind

  function automatic reg_sel_e decode_reg(input logic [7:0] adr);
    reg_sel_e r;
    r = REG_NONE;
    case (adr)
      `ADR_FIRST_CTRL:   r = REG_FIRST_CTRL;
      `ADR_FIRST_LOW:    r = REG_FIRST_LOW;
      `ADR_FIRST_HIGH:   r = REG_FIRST_HIGH;
      `ADR_SECOND_CTRL:  r = REG_SECOND_CTRL;
      `ADR_SECOND_LOW:   r = REG_SECOND_LOW;
      `ADR_SECOND_HIGH:  r = REG_SECOND_HIGH;
      `ADR_EVENT_STATUS: r = REG_STATUS;
      `ADR_EVENT_MASK:   r = REG_MASK;
      default:           r = REG_NONE;
    endcase
    return r;
  endfunction : decode_reg
endpackage : dual_ccp_pkg

// ---- dual_ccp_top.sv ----
// Two capture/compare/PWM units behind a classic Wishbone register slave
//
// Added by the designer: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`include "dual_ccp_consts.svh"
module dual_ccp_top (
  input  wire logic                  clk_i,          // Core clock, 125 MHz
  input  wire logic                  rst_i,          // Synchronous reset, active high
  input  wire logic                  wb_cyc_i,       // Wishbone cycle
  input  wire logic                  wb_stb_i,       // Wishbone strobe
  input  wire logic                  wb_we_i,        // Wishbone write enable
  input  wire logic [7:0]            wb_adr_i,       // Wishbone byte address
  input  wire logic [3:0]            wb_sel_i,       // Wishbone byte selects
  input  wire logic [31:0]           wb_dat_i,       // Wishbone write data
  output logic      [31:0]           wb_dat_o,       // Wishbone read data
  output logic                       wb_ack_o,       // Wishbone acknowledge
  input  wire logic [1:0]            unit_pin_i,     // Unit capture pins, asynchronous
  output logic      [1:0]            unit_pin_o,     // Unit compare and PWM outputs
  input  wire dual_ccp_pkg::word16_t timebase16_i,   // Sixteen bit time base value
  input  wire dual_ccp_pkg::byte_t   pwm_timebase_i, // PWM time base value
  input  wire logic                  pwm_period_i,   // PWM time base period pulse
  input  wire logic                  adc_enabled_i,  // Converter module enabled
  output logic                       tb16_reset_o,   // Reset sixteen bit time base
  output logic                       adc_start_o,    // Start a conversion
  output logic                       irq_o           // Level interrupt
);
  import dual_ccp_pkg::*;

  localparam int UNITS = 2;

  byte_t             unit_control_q [UNITS]; // first_unit_control, second_unit_control
  logic [UNITS-1:0]  status_q;
  logic [UNITS-1:0]  mask_q;
  logic [UNITS-1:0]  pin_meta_q;
  logic [UNITS-1:0]  pin_sync_q;
  logic [UNITS-1:0]  event_p;
  logic [UNITS-1:0]  special_p;
  logic [UNITS-1:0]  status_clr;
  word16_t           value      [UNITS];
  logic              ack_q;
  logic              access;
  logic              wr;
  logic              rd;
  reg_sel_e          sel;
  byte_t             rd_byte;
  logic [31:0]       rdata_q;

  ccp_unit_if unit_bus [UNITS] ();

  // Bus request decode; a new request is taken only while no ack is standing.
  // A write lands at the edge that carries the ack, so the master sees it and the effect together.
  assign access = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr     = wb_cyc_i && wb_stb_i && ack_q && wb_we_i && wb_sel_i[0];
  assign rd     = access && !wb_we_i;
  assign sel    = decode_reg(wb_adr_i);

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i)
  begin
    ack_q <= rst_i ? 1'b0 : access;
  end

  // Two flop synchroniser on the unit pins; the first stage feeds nothing else
  always_ff @(posedge clk_i)
  begin
    pin_meta_q <= rst_i ? '0 : unit_pin_i;
    pin_sync_q <= rst_i ? '0 : pin_meta_q;
  end

  // Both units are the same module; only the outside wiring of the special event differs
  genvar i;
  generate
    for (i = 0; i < UNITS; i++)
    begin : g_unit
      localparam reg_sel_e SEL_CTRL = (i == 0) ? REG_FIRST_CTRL : REG_SECOND_CTRL;
      localparam reg_sel_e SEL_LOW  = (i == 0) ? REG_FIRST_LOW  : REG_SECOND_LOW;
      localparam reg_sel_e SEL_HIGH = (i == 0) ? REG_FIRST_HIGH : REG_SECOND_HIGH;

      // Control register; top two bits unimplemented
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          unit_control_q[i] <= `CTRL_RESET;
        else if (wr && sel == SEL_CTRL)
          unit_control_q[i] <= wb_dat_i[7:0] & `CTRL_IMPL_MASK;
      end

      assign unit_bus[i].ctrl       = unit_control_q[i];
      assign unit_bus[i].wr_low     = wr && (sel == SEL_LOW);
      assign unit_bus[i].wr_high    = wr && (sel == SEL_HIGH);
      assign unit_bus[i].wdata      = wb_dat_i[7:0];
      assign unit_bus[i].pin_sync   = pin_sync_q[i];
      assign unit_bus[i].tb16       = timebase16_i;
      assign unit_bus[i].pwm_tb     = pwm_timebase_i;
      assign unit_bus[i].pwm_period = pwm_period_i;
      assign value[i]               = unit_bus[i].value;
      assign event_p[i]             = unit_bus[i].event_p;
      assign special_p[i]           = unit_bus[i].special_p;
      assign unit_pin_o[i]          = unit_bus[i].pin_o;

      ccp_unit u_unit (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .bus   (unit_bus[i].unit)
      );
    end
  endgenerate

  // Sticky event flags, write one to clear; a new event wins over a clear in the same cycle
  assign status_clr = (wr && sel == REG_STATUS) ? wb_dat_i[UNITS-1:0] : '0;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      status_q <= `EVENT_RESET;
    else
      status_q <= (status_q & ~status_clr) | event_p;
  end

  // Interrupt mask, same layout as the flags
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      mask_q <= `EVENT_RESET;
    else if (wr && sel == REG_MASK)
      mask_q <= wb_dat_i[UNITS-1:0];
  end

  assign irq_o = |(status_q & mask_q);

  // Read multiplexer; unmapped addresses read zero and writes to them are ignored
  always_comb
  begin
    rd_byte = 8'h00;
    case (sel)
      REG_FIRST_CTRL:  rd_byte = unit_control_q[0];
      REG_FIRST_LOW:   rd_byte = value[0][7:0];
      REG_FIRST_HIGH:  rd_byte = value[0][15:8];
      REG_SECOND_CTRL: rd_byte = unit_control_q[1];
      REG_SECOND_LOW:  rd_byte = value[1][7:0];
      REG_SECOND_HIGH: rd_byte = value[1][15:8];
      REG_STATUS:      rd_byte = {6'h00, status_q};
      REG_MASK:        rd_byte = {6'h00, mask_q};
      default:         rd_byte = 8'h00;
    endcase
  end

  // Read data registered with the ack so it stands while ack is high
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdata_q <= `RDATA_RESET;
    else if (rd)
      rdata_q <= {`PAD_BITS, rd_byte};
  end

  assign wb_dat_o = rdata_q;
  assign wb_ack_o = ack_q;

  // Special event: both units clear the time base, only the second starts the converter.
  // Software pairing a capture or compare with a compare is expected to use the special
  // event so the time base is cleared by the match; nothing here enforces it.
  assign tb16_reset_o = special_p[0] | special_p[1];
  assign adc_start_o  = special_p[1] & adc_enabled_i;

  // Checks on bus, flags and triggers
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_read_first_low;
    rd && (sel == REG_FIRST_LOW) ##1 wb_ack_o;
  endsequence

  sequence s_read_second_high;
    rd && (sel == REG_SECOND_HIGH) ##1 wb_ack_o;
  endsequence

  sequence s_read_first_ctrl;
    rd && (sel == REG_FIRST_CTRL) ##1 wb_ack_o;
  endsequence

  chk_ack_single_pulse: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle answer");

  chk_read_first_low: assert property (
    s_read_first_low |-> wb_dat_o == {24'h00_0000, $past(value[0][7:0])})
    else $error("first low byte read wrong");

  chk_read_second_high: assert property (
    s_read_second_high |-> wb_dat_o == {24'h00_0000, $past(value[1][15:8])})
    else $error("second high byte read wrong");

  chk_ctrl_top_zero: assert property (
    s_read_first_ctrl |-> wb_dat_o[7:6] == 2'b00 && wb_dat_o[31:8] == 24'h00_0000)
    else $error("control top bits not zero");

  chk_ctrl_isolated: assert property (
    wr && (sel == REG_SECOND_CTRL) |=> $stable(unit_control_q[0]) &&
      unit_control_q[1] == ($past(wb_dat_i[7:0]) & `CTRL_IMPL_MASK))
    else $error("control write reached the wrong unit");

  chk_flag_set_wins: assert property (
    event_p[0] && status_clr[0] |=> status_q[0] ##1 status_q[0] || $past(status_clr[0]))
    else $error("event lost against clear");

  chk_irq_follows_flag: assert property (
    event_p[1] && mask_q[1] |=> irq_o)
    else $error("unmasked event did not interrupt");

  chk_first_resets_tb: assert property (
    special_p[0] |-> tb16_reset_o && (adc_start_o == (special_p[1] && adc_enabled_i)))
    else $error("first special event wrong");

  chk_second_adc_gate: assert property (
    special_p[1] |-> tb16_reset_o && (adc_start_o == adc_enabled_i))
    else $error("second special event wrong");

  chk_no_stray_trigger: assert property (
    !special_p[0] && !special_p[1] |-> !tb16_reset_o && !adc_start_o)
    else $error("trigger without special event");

  chk_pin_sync_delay: assert property (
    $rose(pin_meta_q[0]) |=> pin_sync_q[0])
    else $error("pin synchroniser delay wrong");
endmodule : dual_ccp_top

// ---- testbench.sv ----
// Self-checking bench for the dual capture/compare block with a register model
`timescale 1ns/1ps
`include "dual_ccp_consts.svh"
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin errors++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); end end
module testbench;
  logic        clk_i, rst_i, cyc, stb, we, run, load, adc_en, tbr, pwm_per, irq_o, ack, adc_st;
  logic [7:0]  adr, pwm_tb;
  logic [3:0]  sel;
  logic [31:0] dat_w, dat_r, r;
  logic [1:0]  pin_in, pin_out;
  logic [15:0] load_val, tb16, v;
  logic [31:0] mdl [8];
  int          errors, check_count, n_tbr, n_adc, hi0, hi1;

  dual_ccp_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
    .unit_pin_i(pin_in), .unit_pin_o(pin_out), .timebase16_i(tb16), .pwm_timebase_i(pwm_tb),
    .pwm_period_i(pwm_per), .adc_enabled_i(adc_en), .tb16_reset_o(tbr), .adc_start_o(adc_st),
    .irq_o(irq_o));
  ccp_timer_partner i_tmr (.clk_i(clk_i), .rst_i(rst_i), .run_i(run), .load_i(load),
    .load_val_i(load_val), .tb16_reset_i(tbr), .tb16_o(tb16), .pwm_tb_o(pwm_tb),
    .pwm_period_o(pwm_per));

  // Clock at 125 MHz
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // Trigger pulses and PWM high time counted mid-cycle, where outputs are settled and no clearing races
  always @(negedge clk_i)
  begin
    if (tbr === 1'b1) n_tbr++;
    if (adc_st === 1'b1) n_adc++;
    if (pin_out[0] === 1'b1) hi0++;
    if (pin_out[1] === 1'b1) hi1++;
  end

  task automatic print_verdict();
    $display("checks=%0d errors=%0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  // Classic single cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    adr   <= a;
    dat_w <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) errors++;
    r = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clk_i); // Idle cycle; the write lands at the ack edge and settles here
  endtask : wb

  // Write and mirror the effect in the model
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
    if (a[7:5] == 3'h0 && a[1:0] == 2'h0) // Unmapped addresses change nothing
    case (a[4:2])
      3'd0, 3'd3: mdl[a[4:2]] = d & 32'h3f;
      3'd6:       mdl[6] = mdl[6] & ~(d & 32'h3);
      3'd7:       mdl[7] = d & 32'h3;
      default:    mdl[a[4:2]] = d & 32'hff;
    endcase
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    `CHK(r, e)
  endtask : rd

  function automatic logic [7:0] ra(input int u, input int k);
    return 8'((u * 12) + (k * 4));
  endfunction : ra

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clk_i);
    errors++;
    print_verdict();
  end

  initial
  begin
    {cyc, stb, we, run, load, adc_en} = '0;
    {adr, dat_w, pin_in, load_val} = '0;
    sel = 4'hf;
    {errors, check_count, n_tbr, n_adc, hi0, hi1} = '0;
    foreach (mdl[i]) mdl[i] = 32'h0;
    void'($urandom(32'h818223e8));
    rst_i = 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    // Every register reads zero after reset
    for (int i = 0; i < 8; i++) rd(8'(i * 4), 32'h0);
    // Top control bits stay zero; each unit keeps its own control
    wr(`ADR_FIRST_CTRL, 32'hff);
    rd(`ADR_FIRST_CTRL, mdl[0]);
    rd(`ADR_SECOND_CTRL, 32'h0);
    wr(`ADR_FIRST_CTRL, 32'h0);
    // Unmapped address: acked, reads zero, write lost
    wr(8'h20, 32'h5a);
    rd(8'h20, 32'h0);
    rd(`ADR_FIRST_CTRL, 32'h0);
    // Both value registers as two bytes each
    for (int u = 0; u < 2; u++)
      for (int k = 1; k < 3; k++)
      begin
        wr(ra(u, k), $urandom);
        rd(ra(u, k), mdl[u * 3 + k]);
      end
    // Capture with a frozen timer, rising edge on the first unit, falling on the second; the second overwrites
    wr(`ADR_EVENT_MASK, 32'h3);
    for (int u = 0; u < 2; u++)
    begin
      wr(ra(u, 0), {28'h0, u ? `MODE_CAP_FALL : `MODE_CAP_RISE});
      for (int k = 0; k < 2; k++)
      begin
        v = 16'($urandom);
        @(posedge clk_i);
        load     <= 1'b1;
        load_val <= v;
        @(posedge clk_i);
        load      <= 1'b0;
        pin_in[u] <= 1'b1;
        repeat (8) @(posedge clk_i);
        pin_in[u] <= 1'b0;
        repeat (8) @(posedge clk_i);
        mdl[u * 3 + 1] = {24'h0, v[7:0]};
        mdl[u * 3 + 2] = {24'h0, v[15:8]};
        mdl[6] = mdl[6] | (32'h1 << u);
        rd(ra(u, 1), mdl[u * 3 + 1]);
        rd(ra(u, 2), mdl[u * 3 + 2]);
        rd(`ADR_EVENT_STATUS, mdl[6]);
      end
      `CHK(irq_o, 1'b1)
      wr(`ADR_EVENT_MASK, 32'h0);
      `CHK(irq_o, 1'b0)
      wr(`ADR_EVENT_MASK, 32'h3);
      wr(`ADR_EVENT_STATUS, 32'h3);
      rd(`ADR_EVENT_STATUS, 32'h0);
      `CHK(irq_o, 1'b0)
      wr(ra(u, 0), 32'h0);
    end
    // Special event: first unit, then the second with the converter enabled and then disabled
    for (int p = 0; p < 3; p++)
    begin
      int u;
      u = (p + 1) / 2;
      wr(ra(u, 1), 32'h40);
      wr(ra(u, 2), 32'h0);
      wr(ra(u, 0), {28'h0, `MODE_CMP_SPECIAL});
      @(posedge clk_i);
      adc_en   <= (p != 2);
      load     <= 1'b1;
      load_val <= 16'h0030;
      run      <= 1'b1;
      @(posedge clk_i);
      load  <= 1'b0;
      n_tbr = 0;
      n_adc = 0;
      repeat (40) @(posedge clk_i);
      run <= 1'b0;
      `CHK(n_tbr, 1)
      `CHK(n_adc, int'(p == 1))
      mdl[6] = mdl[6] | (32'h1 << u);
      rd(`ADR_EVENT_STATUS, mdl[6]);
      wr(ra(u, 0), 32'h0);
      wr(`ADR_EVENT_STATUS, 32'h3);
    end
    // Compare set and clear on the first unit: level on entry, then the match flips the pin
    for (int m = 0; m < 2; m++)
    begin
      wr(`ADR_FIRST_CTRL, {28'h0, m ? `MODE_CMP_CLR : `MODE_CMP_SET});
      @(posedge clk_i);
      `CHK(pin_out[0], 1'(m))
      load     <= 1'b1;
      load_val <= 16'h0030;
      run      <= 1'b1;
      @(posedge clk_i);
      load <= 1'b0;
      repeat (40) @(posedge clk_i);
      run <= 1'b0;
      `CHK(pin_out[0], 1'(m == 0))
      wr(`ADR_FIRST_CTRL, 32'h0);
      wr(`ADR_EVENT_STATUS, 32'h3);
    end
    // PWM on both units: duty low bits from control, common period
    wr(`ADR_FIRST_LOW, 32'h02);
    wr(`ADR_FIRST_CTRL, 32'h3c);
    wr(`ADR_SECOND_LOW, 32'h04);
    wr(`ADR_SECOND_CTRL, 32'h0c);
    repeat (40) @(posedge clk_i);
    hi0 = 0;
    hi1 = 0;
    repeat (16) @(posedge clk_i);
    `CHK(hi0, 3)
    `CHK(hi1, 4)
    print_verdict();
  end
endmodule : testbench
